//--- common/nvm_pkg.sv
// Purpose: shared constants and types for the nonvolatile access control block
// Assumes: core register port with 8-bit index and 8-bit data, 100 MHz SYS_CLK
// Notes: register indices, bit positions and key values are local choices
// Notes on behaviour
// - unlock register stores nothing, always reads zero
// - region 00 targets data EEPROM array
// - region 10 targets program flash array
// - region x1 targets ID and configuration space
// - erase select makes next program flash start an erase
// - erase select ignored for data EEPROM
// - program or erase only while gate set
// - write-enable gate cleared at power-up
// - error flag set on start, cleared on success
// - EEPROM start erases-then-writes; flash start writes
// - firmware can only set write-start bit
// - hardware clears write-start bit at completion
// - done flag sticky until firmware clears it
// - 8-bit table latch in register space
// - 22-bit pointer; ID space selected by region bit 6, not by the pointer
// - table read uses all pointer bits
// - table write fills holding register by low bits
// - flash write uses pointer upper bits only
`default_nettype none

package nvm_pkg;
  localparam int PTR_W = 22;
  localparam int DATA_W = 8;
  localparam int REG_AW = 8;

  localparam logic [REG_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] ADDR_UNLOCK = 8'h01;
  localparam logic [REG_AW-1:0] ADDR_LATCH = 8'h02;
  localparam logic [REG_AW-1:0] ADDR_PTR_L = 8'h03;
  localparam logic [REG_AW-1:0] ADDR_PTR_H = 8'h04;
  localparam logic [REG_AW-1:0] ADDR_PTR_U = 8'h05;
  localparam logic [REG_AW-1:0] ADDR_IRQ7 = 8'h06;

  localparam int CTL_REGION_LO = 6;
  localparam int CTL_ERASE = 4;
  localparam int CTL_WRITE_ERROR_FLAG = 3;
  localparam int CTL_WRITE_ENABLE_GATE = 2;
  localparam int CTL_WR = 1;
  localparam int IRQ_DONE = 5;

  localparam logic [1:0] REGION_EE = 2'h0;
  localparam logic [1:0] REGION_PF = 2'h2;

  localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 8'haa;

  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 2000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_READ = 3'h1,
    OP_EE_WRITE = 3'h2,
    OP_PF_WRITE = 3'h3,
    OP_PF_ERASE = 3'h4,
    OP_CFG_WRITE = 3'h5
  } mem_op_t;

  typedef struct packed {
    logic rd;
    logic wr;
    mem_op_t op;
    logic [PTR_W-1:0] addr;
  } mem_req_t;
endpackage : nvm_pkg

`default_nettype wire

//--- rtl/nvm_access_control.sv
// Purpose: control, unlock, table latch and program timing for on-chip storage
// Assumes: core register strobes and table op strobes are synchronous one-cycle pulses
// Notes: arrays sit outside; they take MEM_REQ and read holding bytes by index
`default_nettype none

module nvm_access_control #(
  parameter int HOLD_BITS = 5,
  parameter int PROG_CYC = nvm_pkg::PROG_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic REG_WR,
  input wire logic [nvm_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [nvm_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic TBL_RD,
  input wire logic TBL_WR,
  input wire logic MEM_RD_VALID,
  input wire logic [nvm_pkg::DATA_W-1:0] MEM_RD_DATA,
  input wire logic [HOLD_BITS-1:0] MEM_HOLD_IDX,
  output logic [nvm_pkg::DATA_W-1:0] REG_RDATA,
  output nvm_pkg::mem_req_t MEM_REQ,
  output logic [nvm_pkg::DATA_W-1:0] MEM_HOLD_DATA,
  output logic NVM_BUSY,
  output logic NVM_DONE
);
  import nvm_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_PROG = 3'b100
  } state_t;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b001,
    UL_KEY1 = 3'b010,
    UL_ARMED = 3'b100
  } unlock_t;

  function automatic mem_op_t write_op(input logic [1:0] region, input logic erase);
    if (region[0]) begin
      write_op = OP_CFG_WRITE;
    end else if (region == REGION_EE) begin
      write_op = OP_EE_WRITE;
    end else if (erase) begin
      write_op = OP_PF_ERASE;
    end else begin
      write_op = OP_PF_WRITE;
    end
  endfunction : write_op

  state_t state_q, state_d;
  unlock_t unlock_q, unlock_d;
  logic [1:0] region_q;
  logic erase_q, write_enable_gate_q, write_error_flag_q, wr_q, done_q;
  logic [DATA_W-1:0] latch_q;
  logic [PTR_W-1:0] ptr_q;
  logic [DATA_W-1:0] hold_mem [2**HOLD_BITS];
  logic [$clog2(PROG_CYC+1)-1:0] cnt_q;

  wire wr_ctrl = REG_WR && (REG_ADDR == ADDR_CTRL);
  wire wr_unlock = REG_WR && (REG_ADDR == ADDR_UNLOCK);
  wire wr_latch = REG_WR && (REG_ADDR == ADDR_LATCH);
  wire wr_irq = REG_WR && (REG_ADDR == ADDR_IRQ7);
  wire idle = (state_q == ST_IDLE);
  wire prog_done = (state_q == ST_PROG) && (cnt_q == '0);
  // a start needs the gate, the unlock pair just before, and no cycle in flight
  wire start_wr = wr_ctrl && REG_WDATA[CTL_WR] && write_enable_gate_q && (unlock_q == UL_ARMED) && idle;
  wire start_rd = TBL_RD && idle;
  wire rd_load = (state_q == ST_READ) && MEM_RD_VALID;
  wire mem_op_t op_sel = write_op(region_q, erase_q);
  wire [PTR_W-1:0] blk_addr = {ptr_q[PTR_W-1:HOLD_BITS], {HOLD_BITS{1'b0}}};
  wire [PTR_W-1:0] wr_addr = (op_sel == OP_EE_WRITE) ? ptr_q : blk_addr;
  wire [DATA_W-1:0] ctrl_view = {region_q, 1'b0, erase_q, write_error_flag_q, write_enable_gate_q, wr_q, 1'b0};

  logic [DATA_W-1:0] rdata_d;
  always_comb begin
    case (REG_ADDR)
      ADDR_CTRL: rdata_d = ctrl_view;
      ADDR_UNLOCK: rdata_d = '0;
      ADDR_LATCH: rdata_d = latch_q;
      ADDR_PTR_L: rdata_d = ptr_q[7:0];
      ADDR_PTR_H: rdata_d = ptr_q[15:8];
      ADDR_PTR_U: rdata_d = {2'h0, ptr_q[PTR_W-1:16]};
      ADDR_IRQ7: rdata_d = (DATA_W'(done_q) << IRQ_DONE);
      default: rdata_d = '0;
    endcase
  end

  always_comb begin
    unlock_d = unlock_q;
    case (unlock_q)
      UL_IDLE: if (wr_unlock && REG_WDATA == UNLOCK_KEY1) unlock_d = UL_KEY1;
      UL_KEY1: if (wr_unlock) unlock_d = (REG_WDATA == UNLOCK_KEY2) ? UL_ARMED : UL_IDLE;
      UL_ARMED: if (REG_WR) unlock_d = UL_IDLE; // any register write spends the arming
      default: unlock_d = UL_IDLE;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start_wr) state_d = ST_PROG; else if (start_rd) state_d = ST_READ;
      ST_READ: if (MEM_RD_VALID) state_d = ST_IDLE;
      ST_PROG: if (cnt_q == '0) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      unlock_q <= UL_IDLE;
    end else begin
      state_q <= state_d;
      unlock_q <= unlock_d;
    end
  end

  // control register; gate comes up clear so nothing programs by accident
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      region_q <= REGION_EE;
      erase_q <= 1'b0;
      write_enable_gate_q <= 1'b0;
    end else if (wr_ctrl) begin
      region_q <= REGION_EE | REG_WDATA[CTL_REGION_LO +: 2];
      erase_q <= REG_WDATA[CTL_ERASE];
      write_enable_gate_q <= REG_WDATA[CTL_WRITE_ENABLE_GATE];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      wr_q <= 1'b0;
      write_error_flag_q <= 1'b0;
      cnt_q <= '0;
    end else if (start_wr) begin
      wr_q <= 1'b1;
      write_error_flag_q <= 1'b1;
      cnt_q <= ($bits(cnt_q))'(PROG_CYC - 1);
    end else if (prog_done) begin
      wr_q <= 1'b0;
      write_error_flag_q <= 1'b0;
    end else if (state_q == ST_PROG) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // a completion in the same cycle as a firmware clear keeps the flag set
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      done_q <= 1'b0;
    end else begin
      done_q <= prog_done | (wr_irq ? REG_WDATA[IRQ_DONE] : done_q);
    end
  end

  // array data wins over a same-cycle register write to the latch
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      latch_q <= '0;
    end else if (rd_load) begin
      latch_q <= MEM_RD_DATA;
    end else if (wr_latch) begin
      latch_q <= REG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ptr_q <= '0;
    end else if (REG_WR) begin
      if (REG_ADDR == ADDR_PTR_L) ptr_q[7:0] <= REG_WDATA;
      if (REG_ADDR == ADDR_PTR_H) ptr_q[15:8] <= REG_WDATA;
      if (REG_ADDR == ADDR_PTR_U) ptr_q[PTR_W-1:16] <= REG_WDATA[PTR_W-17:0];
    end
  end

  // holding block is plain storage; contents are not reset
  always_ff @(posedge SYS_CLK) begin
    if (TBL_WR) hold_mem[ptr_q[HOLD_BITS-1:0]] <= latch_q;
    MEM_HOLD_DATA <= hold_mem[MEM_HOLD_IDX];
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      MEM_REQ <= '0;
      REG_RDATA <= '0;
      NVM_BUSY <= 1'b0;
      NVM_DONE <= 1'b0;
    end else begin
      MEM_REQ.rd <= start_rd && !start_wr;
      MEM_REQ.wr <= start_wr;
      if (start_wr) begin
        MEM_REQ.op <= op_sel;
        MEM_REQ.addr <= wr_addr;
      end else if (start_rd) begin
        MEM_REQ.op <= OP_READ;
        MEM_REQ.addr <= ptr_q;
      end
      REG_RDATA <= rdata_d;
      NVM_BUSY <= (state_d != ST_IDLE);
      NVM_DONE <= done_q | prog_done;
    end
  end

  wire ee_sel = (region_q == REGION_EE);
  wire pf_sel = (region_q == REGION_PF);

  a_unlock_zero: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (REG_ADDR == ADDR_UNLOCK) |=> (REG_RDATA == '0)) else $error("unlock register read nonzero");
  a_ee_region_op: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (start_wr && ee_sel) |=> (MEM_REQ.wr && MEM_REQ.op == OP_EE_WRITE)) else $error("eeprom op wrong");
  a_pf_write_op: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (start_wr && pf_sel && !erase_q) |=> (MEM_REQ.op == OP_PF_WRITE)) else $error("flash write op wrong");
  a_cfg_region_op: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (start_wr && region_q[0]) |=> (MEM_REQ.op == OP_CFG_WRITE)) else $error("config op wrong");
  a_pf_erase_op: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (start_wr && pf_sel && erase_q) |=> (MEM_REQ.op == OP_PF_ERASE)) else $error("flash erase op wrong");
  a_gate_needed: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(wr_q) |-> $past(write_enable_gate_q)) else $error("start without write-enable gate");
  a_error_on_start: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(wr_q) |-> write_error_flag_q ##0 NVM_BUSY) else $error("error flag not set at start");
  a_start_sticky: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_q && !prog_done) |=> wr_q) else $error("start bit dropped early");
  a_start_cleared: assert property (@(posedge SYS_CLK) disable iff (RESET)
    prog_done |=> (!wr_q && !write_error_flag_q && NVM_DONE)) else $error("completion not reflected");
  a_done_sticky: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (done_q && !wr_irq) |=> done_q) else $error("done flag lost");
  a_block_align: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (MEM_REQ.wr && MEM_REQ.op == OP_PF_WRITE) |-> (MEM_REQ.addr[HOLD_BITS-1:0] == '0)) else $error("block addr low bits");
  a_read_latch: assert property (@(posedge SYS_CLK) disable iff (RESET)
    rd_load |=> (latch_q == $past(MEM_RD_DATA))) else $error("latch not loaded from array");
  a_busy_ignore: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_q == ST_PROG) |-> !start_wr) else $error("start accepted while busy");

  c_ee_write: cover property (@(posedge SYS_CLK) disable iff (RESET) start_wr && ee_sel);
  c_pf_erase: cover property (@(posedge SYS_CLK) disable iff (RESET) start_wr && pf_sel && erase_q);
  c_table_read: cover property (@(posedge SYS_CLK) disable iff (RESET) rd_load);
  c_done_clear_race: cover property (@(posedge SYS_CLK) disable iff (RESET) prog_done && wr_irq);
endmodule : nvm_access_control

`default_nettype wire

//--- verification/mem_model.sv
// Purpose: storage array stand-in answering table reads
// Assumes: one outstanding read, answer after DLY cycles
// Notes: read data bus toggles when not answering
`default_nettype none
module mem_model #(
  parameter int DLY = 3
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire nvm_pkg::mem_req_t MEM_REQ,
  output logic MEM_RD_VALID,
  output logic [7:0] MEM_RD_DATA
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      cnt <= 0;
      MEM_RD_VALID <= 1'b0;
      MEM_RD_DATA <= 8'h00;
    end else begin
      MEM_RD_VALID <= (cnt == 1);
      // byte derived from the pointer's low byte only
      MEM_RD_DATA <= (cnt == 1) ? MEM_REQ.addr[7:0] ^ 8'h5a : ~MEM_RD_DATA;
      if (MEM_REQ.rd) cnt <= DLY;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : mem_model
`default_nettype wire

//--- verification/testbench.sv
// Purpose: register-level test of the storage access control
// Assumes: PROG_CYC shortened to 40, HOLD_BITS 5
// Notes: inputs change 1 ns after the rising edge
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import nvm_pkg::*;
  logic SYS_CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, TBL_RD = 1'b0, TBL_WR = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, MEM_RD_DATA, MEM_HOLD_DATA, v;
  logic [4:0] MEM_HOLD_IDX = 5'h00;
  logic MEM_RD_VALID, NVM_BUSY, NVM_DONE;
  mem_req_t MEM_REQ, cap;
  int n_mismatch = 0, checks_done = 0, n_wr = 0, n_rd = 0, cyc = 0, n0;
  logic [7:0] ctl_tab [6] = '{8'h04, 8'h14, 8'h84, 8'h94, 8'h44, 8'hd4};
  mem_op_t op_tab [6] = '{OP_EE_WRITE, OP_EE_WRITE, OP_PF_WRITE, OP_PF_ERASE, OP_CFG_WRITE, OP_CFG_WRITE};
  localparam logic [21:0] PTR = 22'h2abcdf;
  nvm_access_control #(.HOLD_BITS(5), .PROG_CYC(40)) DUT (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .TBL_RD(TBL_RD), .TBL_WR(TBL_WR),
    .MEM_RD_VALID(MEM_RD_VALID), .MEM_RD_DATA(MEM_RD_DATA), .MEM_HOLD_IDX(MEM_HOLD_IDX),
    .REG_RDATA(REG_RDATA), .MEM_REQ(MEM_REQ), .MEM_HOLD_DATA(MEM_HOLD_DATA), .NVM_BUSY(NVM_BUSY),
    .NVM_DONE(NVM_DONE));
  mem_model #(.DLY(3)) far_end (.SYS_CLK(SYS_CLK), .RESET(RESET), .MEM_REQ(MEM_REQ),
    .MEM_RD_VALID(MEM_RD_VALID), .MEM_RD_DATA(MEM_RD_DATA));
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (MEM_REQ.wr === 1'b1) begin
      n_wr++;
      cap = MEM_REQ;
    end
    if (MEM_REQ.rd === 1'b1) begin
      n_rd++;
      cap = MEM_REQ;
    end
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge SYS_CLK);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    tick();
    REG_WR = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    REG_ADDR = a;
    tick();
    v = REG_RDATA;
  endtask : rd
  task automatic unlock();
    wr(ADDR_UNLOCK, UNLOCK_KEY1);
    wr(ADDR_UNLOCK, UNLOCK_KEY2);
  endtask : unlock
  task automatic wait_done();
    for (int i = 0; i < 100 && NVM_DONE !== 1'b1; i++) tick();
  endtask : wait_done
  task automatic prog(input logic [7:0] c, input mem_op_t op);
    wr(ADDR_CTRL, c);
    n0 = n_wr;
    unlock();
    wr(ADDR_CTRL, c | 8'h02);
    chk(n_wr, n0 + 1);
    chk(cap.op, op);
    chk(cap.addr, (op == OP_EE_WRITE) ? PTR : {PTR[21:5], 5'h00});
    rd(ADDR_CTRL);
    chk(v[3:1], 3'b111);
    chk(NVM_BUSY, 1'b1);
    wr(ADDR_CTRL, c);
    rd(ADDR_CTRL);
    chk(v[1], 1'b1);
    unlock();
    wr(ADDR_CTRL, c | 8'h02);
    chk(n_wr, n0 + 1);
    wait_done();
    chk(NVM_BUSY, 1'b0);
    rd(ADDR_CTRL);
    chk({v[3], v[1]}, 2'b00);
    rd(ADDR_IRQ7);
    chk(v[IRQ_DONE], 1'b1);
    wr(ADDR_IRQ7, 8'h00);
    chk(NVM_DONE, 1'b0);
  endtask : prog
  initial begin
    repeat (10) @(posedge SYS_CLK);
    #1;
    RESET = 1'b0;
    rd(ADDR_CTRL);
    chk(v, 8'h00);
    // second key alone leaves the sequence idle, so the keyed start below is truly armed
    wr(ADDR_UNLOCK, UNLOCK_KEY2);
    rd(ADDR_UNLOCK);
    chk(v, 8'h00);
    wr(8'h07, 8'hff);
    rd(8'h07);
    chk(v, 8'h00);
    // gate still clear: a keyed start must be dropped
    unlock();
    wr(ADDR_CTRL, 8'h82);
    chk(n_wr, 0);
    rd(ADDR_CTRL);
    chk(v, 8'h80);
    wr(ADDR_PTR_L, PTR[7:0]);
    wr(ADDR_PTR_H, PTR[15:8]);
    wr(ADDR_PTR_U, {2'b00, PTR[21:16]});
    TBL_RD = 1'b1;
    tick();
    TBL_RD = 1'b0;
    for (int i = 0; i < 20 && NVM_BUSY !== 1'b0; i++) tick();
    chk(NVM_BUSY, 1'b0);
    chk(n_rd, 1);
    chk(cap.op, OP_READ);
    chk(cap.addr, PTR);
    rd(ADDR_LATCH);
    chk(v, PTR[7:0] ^ 8'h5a);
    wr(ADDR_LATCH, 8'h3c);
    TBL_WR = 1'b1;
    tick();
    TBL_WR = 1'b0;
    MEM_HOLD_IDX = PTR[4:0];
    tick();
    tick();
    chk(MEM_HOLD_DATA, 8'h3c);
    rd(ADDR_LATCH);
    chk(v, 8'h3c);
    for (int k = 0; k < 6; k++) prog(ctl_tab[k], op_tab[k]);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
